// >>> src/scd_consts.vh
// constants for the single channel duty pwm driver
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets (word aligned)
// ------------------------------------------------------------
`define SCD_OFS_CTRL 8'h00
`define SCD_OFS_PERIOD 8'h04
`define SCD_OFS_PHASE 8'h08
`define SCD_OFS_DUTY 8'h0c
`define SCD_OFS_INIT 8'h10
`define SCD_OFS_COMPARE_A_COUNT 8'h14
`define SCD_OFS_COMPARE_B_COUNT 8'h18
`define SCD_OFS_COUNT 8'h1c
`define SCD_OFS_INST 8'h20
`define SCD_OFS_PCOPY 8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SCD_CTRL_RUN 0
`define SCD_CTRL_MASTER 1
`define SCD_INIT_GO 0

// ------------------------------------------------------------
// fixed point and reset values
// ------------------------------------------------------------
`define SCD_DUTY_FRAC 24
`define SCD_MODE_MASTER 1'b1
`define SCD_MODE_SLAVE 1'b0
`define SCD_RST_MODE 1'b1
`define SCD_RST_RUN 1'b0
`define SCD_RST_PERIOD 16'hffff
`define SCD_RST_ZERO16 16'h0000
`define SCD_RST_ZERO32 32'h0000_0000
`define SCD_PERIOD_ADJ 16'h0001

// ------------------------------------------------------------
// ahb-lite encodings
// ------------------------------------------------------------
`define SCD_HTRANS_NONSEQ_BIT 1
`define SCD_HRESP_OKAY 1'b0

`endif

// >>> src/scd_pwm_top.v
// single channel duty pwm driver with ahb-lite register slave
// ------------------------------------------------------------
// Function
// - duty Q24 times stored period gives integer compare A count.
// - each compare A update also loads compare B with half of it.
// - instance number picks target channel and its stored period copy.
// - time base counts up only, wrapping to zero after period register.
// - mode 1 is master ignoring sync, mode 0 is slave following sync.
// - slave loads phase offset into counter on sync; master ignores phase.
// - written period is clocks per cycle; register keeps that minus one.
// - internal Q0 period copy, below 65536, is used for duty scaling.
// ------------------------------------------------------------
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "scd_consts.vh"

module scd_pwm_top #(
  parameter NCH = 2,
  parameter IW = 1,
  parameter PW = 16
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  input wire timebase_sync_input_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg [NCH-1:0] pwm_a_o,
  output reg [NCH-1:0] soc_b_o
);

  // ------------------------------------------------------------
  // per channel state
  // ------------------------------------------------------------
  reg [PW-1:0] timebase_period_reg [0:NCH-1];
  reg [PW-1:0] stored_period_copy [0:NCH-1];
  reg [PW-1:0] phase_q [0:NCH-1];
  reg [PW-1:0] compare_a_count [0:NCH-1];
  reg [PW-1:0] compare_b_count [0:NCH-1];
  reg [PW-1:0] count_q [0:NCH-1];
  reg [31:0] duty_input [0:NCH-1];
  reg [NCH-1:0] run_q;
  reg [NCH-1:0] master_q;
  reg [IW-1:0] inst_q;
  reg sync_prev_q;

  // ------------------------------------------------------------
  // bus slave state
  // ------------------------------------------------------------
  reg dphase_q;
  reg dwrite_q;
  reg [7:0] daddr_q;

  wire addr_take;
  wire inst_ok;
  wire sync_evt;
  wire [PW+32-1:0] duty_prod;
  wire [PW-1:0] duty_cnt;
  reg [31:0] rd_mux;
  reg wr_ctrl;
  reg wr_period;
  reg wr_phase;
  reg wr_duty;
  reg wr_init;
  reg wr_inst;
  integer i;
  wire [PW-1:0] count_d [0:NCH-1];
  wire [NCH-1:0] pwm_d;
  wire [NCH-1:0] soc_d;
  genvar g;

  assign addr_take = hsel_i & htrans_i[`SCD_HTRANS_NONSEQ_BIT] & hready_i;
  // writes aimed at an instance that does not exist are dropped
  assign inst_ok = ({{(32-IW){1'b0}}, inst_q} < NCH);
  assign sync_evt = timebase_sync_input_i & ~sync_prev_q;

  // ------------------------------------------------------------
  // duty scaling
  // ------------------------------------------------------------
  // product of Q24 duty and integer period; dropping 24 fraction bits gives Q0
  assign duty_prod = hwdata_i * stored_period_copy[inst_q];
  assign duty_cnt = duty_prod[`SCD_DUTY_FRAC +: PW];

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  always @* begin
    wr_ctrl = 1'b0;
    wr_period = 1'b0;
    wr_phase = 1'b0;
    wr_duty = 1'b0;
    wr_init = 1'b0;
    wr_inst = 1'b0;
    if (dphase_q && dwrite_q) begin
      case (daddr_q)
        `SCD_OFS_CTRL: wr_ctrl = inst_ok;
        `SCD_OFS_PERIOD: wr_period = inst_ok;
        `SCD_OFS_PHASE: wr_phase = inst_ok;
        `SCD_OFS_DUTY: wr_duty = inst_ok;
        `SCD_OFS_INIT: wr_init = inst_ok & hwdata_i[`SCD_INIT_GO];
        `SCD_OFS_INST: wr_inst = 1'b1;
        default: wr_ctrl = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read mux, shows the channel picked by the instance register
  // ------------------------------------------------------------
  always @* begin
    rd_mux = `SCD_RST_ZERO32;
    if (inst_ok) begin
      case (daddr_q)
        `SCD_OFS_CTRL: begin
          rd_mux[`SCD_CTRL_RUN] = run_q[inst_q];
          rd_mux[`SCD_CTRL_MASTER] = master_q[inst_q];
        end
        `SCD_OFS_PERIOD: rd_mux[PW-1:0] = timebase_period_reg[inst_q];
        `SCD_OFS_PHASE: rd_mux[PW-1:0] = phase_q[inst_q];
        `SCD_OFS_DUTY: rd_mux = duty_input[inst_q];
        `SCD_OFS_COMPARE_A_COUNT: rd_mux[PW-1:0] = compare_a_count[inst_q];
        `SCD_OFS_COMPARE_B_COUNT: rd_mux[PW-1:0] = compare_b_count[inst_q];
        `SCD_OFS_COUNT: rd_mux[PW-1:0] = count_q[inst_q];
        `SCD_OFS_INST: rd_mux[IW-1:0] = inst_q;
        `SCD_OFS_PCOPY: rd_mux[PW-1:0] = stored_period_copy[inst_q];
        default: rd_mux = `SCD_RST_ZERO32;
      endcase
    end else if (daddr_q == `SCD_OFS_INST) begin
      rd_mux[IW-1:0] = inst_q;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave: one wait state so read data leaves a flip-flop
  // ------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dphase_q <= 1'b0;
      dwrite_q <= 1'b0;
      daddr_q <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= `SCD_HRESP_OKAY;
      hrdata_o <= `SCD_RST_ZERO32;
    end else begin
      hresp_o <= `SCD_HRESP_OKAY;
      if (dphase_q) begin
        dphase_q <= 1'b0;
        hreadyout_o <= 1'b1;
        if (!dwrite_q) begin
          hrdata_o <= rd_mux;
        end
      end else if (addr_take) begin
        dphase_q <= 1'b1;
        dwrite_q <= hwrite_i;
        daddr_q <= {haddr_i[7:2], 2'b00};
        hreadyout_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inst_q <= {IW{1'b0}};
      run_q <= {NCH{`SCD_RST_RUN}};
      master_q <= {NCH{`SCD_RST_MODE}};
      for (i = 0; i < NCH; i = i + 1) begin
        timebase_period_reg[i] <= `SCD_RST_PERIOD;
        stored_period_copy[i] <= `SCD_RST_ZERO16;
        phase_q[i] <= `SCD_RST_ZERO16;
        duty_input[i] <= `SCD_RST_ZERO32;
        compare_a_count[i] <= `SCD_RST_ZERO16;
        compare_b_count[i] <= `SCD_RST_ZERO16;
      end
    end else begin
      if (wr_inst) begin
        inst_q <= hwdata_i[IW-1:0];
      end
      if (wr_ctrl) begin
        run_q[inst_q] <= hwdata_i[`SCD_CTRL_RUN];
        master_q[inst_q] <= hwdata_i[`SCD_CTRL_MASTER];
      end
      if (wr_period) begin
        // argument is clocks per cycle, up-counting needs one less
        timebase_period_reg[inst_q] <= hwdata_i[PW-1:0] - `SCD_PERIOD_ADJ;
      end
      if (wr_phase) begin
        phase_q[inst_q] <= hwdata_i[PW-1:0];
      end
      if (wr_init) begin
        // the copy only follows the period register on an init step
        stored_period_copy[inst_q] <= timebase_period_reg[inst_q];
      end
      if (wr_duty) begin
        duty_input[inst_q] <= hwdata_i;
        compare_a_count[inst_q] <= duty_cnt;
        compare_b_count[inst_q] <= {1'b0, duty_cnt[PW-1:1]};
      end
    end
  end

  // ------------------------------------------------------------
  // time base, sync and output generation
  // ------------------------------------------------------------
  // one next-state stage per channel, all flopped in the process below
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      scd_pwm_step #(
        .PW(PW)
      ) u_step (
        .run_i(run_q[g]),
        .slave_sync_i(sync_evt & (master_q[g] == `SCD_MODE_SLAVE)),
        .pwm_i(pwm_a_o[g]),
        .count_i(count_q[g]),
        .period_i(timebase_period_reg[g]),
        .phase_i(phase_q[g]),
        .compare_a_count_i(compare_a_count[g]),
        .compare_b_count_i(compare_b_count[g]),
        .count_o(count_d[g]),
        .pwm_o(pwm_d[g]),
        .soc_o(soc_d[g])
      );
    end
  endgenerate

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_prev_q <= 1'b0;
      pwm_a_o <= {NCH{1'b0}};
      soc_b_o <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        count_q[i] <= `SCD_RST_ZERO16;
      end
    end else begin
      sync_prev_q <= timebase_sync_input_i;
      pwm_a_o <= pwm_d;
      soc_b_o <= soc_d;
      for (i = 0; i < NCH; i = i + 1) begin
        count_q[i] <= count_d[i];
      end
    end
  end

endmodule

// ------------------------------------------------------------
// per channel next state of counter, output a and conversion start
// ------------------------------------------------------------
module scd_pwm_step #(
  parameter PW = 16
) (
  input wire run_i,
  input wire slave_sync_i,
  input wire pwm_i,
  input wire [PW-1:0] count_i,
  input wire [PW-1:0] period_i,
  input wire [PW-1:0] phase_i,
  input wire [PW-1:0] compare_a_count_i,
  input wire [PW-1:0] compare_b_count_i,
  output reg [PW-1:0] count_o,
  output reg pwm_o,
  output reg soc_o
);

  always @* begin
    // stopped channel holds its counter and parks output low
    count_o = count_i;
    pwm_o = 1'b0;
    soc_o = 1'b0;
    if (run_i) begin
      pwm_o = pwm_i;
      if (slave_sync_i) begin
        count_o = phase_i;
      end else if (count_i >= period_i) begin
        count_o = `SCD_RST_ZERO16;
      end else begin
        count_o = count_i + `SCD_PERIOD_ADJ;
      end
      // a zero compare wins over the zero point, so zero duty stays low
      if (count_i == compare_a_count_i) begin
        pwm_o = 1'b0;
      end else if (count_i == `SCD_RST_ZERO16) begin
        pwm_o = 1'b1;
      end
      if (count_i == compare_b_count_i) begin
        soc_o = 1'b1;
      end
    end
  end

endmodule

// >>> tb/scd_pwm_checker.sv
// port checker for the single channel duty pwm driver
module scd_pwm_checker #(
  parameter NCH = 2
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [NCH-1:0] pwm_a_o,
  input wire logic [NCH-1:0] soc_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic take = hsel_i && htrans_i[1] && hready_i;
  resp_okay_a: assert property (hresp_o == 1'h0) else $error("hresp not okay");
  wait_state_a: assert property (take |=> !hreadyout_o ##1 hreadyout_o) else $error("bad wait state");
  short_wait_a: assert property (!hreadyout_o |=> hreadyout_o) else $error("wait too long");
  ready_idle_a: assert property (hreadyout_o && !take |=> hreadyout_o) else $error("ready dropped");
  rdata_hold_a: assert property (!$rose(hreadyout_o) |-> $stable(hrdata_o)) else $error("rdata moved");
  soc_pulse_a: assert property (soc_b_o[0] |=> !soc_b_o[0]) else $error("soc0 too long");
  soc_pulse1_a: assert property (soc_b_o[1] |=> !soc_b_o[1]) else $error("soc1 too long");
  fall_apart_a: assert property ($fell(pwm_a_o[1]) |-> !soc_b_o[1]) else $error("fall at soc");
endmodule

bind scd_pwm_top scd_pwm_checker #(.NCH(NCH)) u_chk (.core_clk_i, .reset_n_i, .hsel_i, .htrans_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .pwm_a_o, .soc_b_o);

// >>> tb/scd_switch_model.sv
// power switch model: measures on time and cycle length of its gate
module scd_switch_model (
  input wire logic clk_i,
  input wire logic gate_i,
  output int on_o,
  output int len_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int on_q = 0;
  int len_q = 0;
  logic prev_q = 1'h0;
  // a new cycle starts at each turn-on of the gate
  always @(posedge clk_i) begin
    prev_q <= gate_i;
    if (gate_i && !prev_q) begin
      on_o <= on_q;
      len_o <= len_q;
      on_q <= 1;
      len_q <= 1;
    end else begin
      on_q <= on_q + int'(gate_i);
      len_q <= len_q + 1;
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the single channel duty pwm driver
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, sync = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hrdy, hresp;
  wire logic [1:0] pwm_a, soc_b;
  int mismatches = 0, checks = 0, on_n, len_n, n;
  always #25 clk = ~clk;
  scd_pwm_top u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .timebase_sync_input_i(sync),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .pwm_a_o(pwm_a), .soc_b_o(soc_b));
  scd_switch_model u_sw (.clk_i(clk), .gate_i(pwm_a[1]), .on_o(on_n), .len_o(len_n));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, a, 32'h0, x);
    chk(nm, x, e);
  endtask
  // edges from sync until the next turn-on is seen; starts just after a turn-off
  task automatic probe(input int e);
    while (pwm_a[1] !== 1'h1) @(posedge clk);
    while (pwm_a[1] !== 1'h0) @(posedge clk);
    sync <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pwm_a[1] !== 1'h1 && n < 50);
    sync <= 1'h0;
    chk("sync_to_rise", n, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    chk("pwm_rst", {30'h0, pwm_a}, 32'h0);
    rdc("period_rst", 8'h04, 32'h0000_ffff);
    rdc("ctrl_rst", 8'h00, 32'h2);
    wr(8'h04, 32'h0000_0258);
    rdc("period", 8'h04, 32'h0000_0257);
    wr(8'h10, 32'h1);
    rdc("copy", 8'h24, 32'h0000_0257);
    wr(8'h0c, 32'h0080_0000);
    rdc("cmp_a_half", 8'h14, 32'h0000_012b);
    rdc("cmp_b_half", 8'h18, 32'h0000_0095);
    wr(8'h0c, 32'h00ff_ffff);
    rdc("cmp_a_max", 8'h14, 32'h0000_0256);
    rdc("cmp_b_max", 8'h18, 32'h0000_012b);
    rdc("unmapped", 8'h3c, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h04, 32'h0000_000a);
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h0080_0000);
    rdc("cmp_a_ch1", 8'h14, 32'h4);
    wr(8'h08, 32'h5);
    wr(8'h00, 32'h3);
    repeat (40) @(posedge clk);
    chk("on_cycles", on_n, 32'h4);
    chk("cycle_len", len_n, 32'ha);
    while (pwm_a[1] !== 1'h1) @(posedge clk);
    n = 0;
    while (soc_b[1] !== 1'h1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("soc_after_rise", n, 32'h2);
    probe(6);
    wr(8'h00, 32'h1);
    probe(8);
    wr(8'h20, 32'h0);
    rdc("cmp_a_ch0", 8'h14, 32'h0000_0256);
    chk("hresp", {31'h0, hresp}, 32'h0);
    complete_run();
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
